// ### common/rtsi_pkg.sv
// constants and types of the trigger, terminator and status reply interpreter
package rtsi_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	// config register fields and reset
	localparam int CFG_P_LSB = 0;
	localparam int CFG_D_LSB = 4;
	localparam int CFG_F_LSB = 8;
	localparam int CFG_K_LSB = 12;
	localparam int CFG_R_LSB = 16;
	localparam logic [31:0] CFG_RESET = 32'h0000_0002;
	localparam logic [31:0] DATA_RESET = 32'h3030_3030;
	// status register fields
	localparam int STAT_TRIG_LSB = 0;
	localparam int STAT_RUN_BIT = 3;
	localparam int STAT_TERM_LSB = 4;
	localparam int STAT_SELFTEST_BIT = 6;
	localparam int STAT_ILLEGAL_BIT = 7;
	localparam int STAT_PTR_LSB = 8;
	localparam int STAT_SRQ_LSB = 16;
	localparam int STAT_PREFIX_LSB = 24;
	// program modes
	localparam logic [1:0] PROG_SINGLE = 2'h0;
	localparam logic [1:0] PROG_CONT = 2'h1;
	localparam logic [1:0] PROG_STEP = 2'h2;
	// mode defaults and limits
	localparam logic [2:0] TRIG_DEFAULT = 3'h6;
	localparam logic [2:0] PREFIX_DEFAULT = 3'h0;
	localparam logic [2:0] PREFIX_MAX = 3'h5;
	localparam logic [7:0] SRQ_MAX = 8'h63;
	// command letters and characters
	localparam logic [7:0] CMD_T = 8'h54;
	localparam logic [7:0] CMD_Y = 8'h59;
	localparam logic [7:0] CMD_U = 8'h55;
	localparam logic [7:0] CMD_G = 8'h47;
	localparam logic [7:0] CMD_M = 8'h4d;
	localparam logic [7:0] CMD_J = 8'h4a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_DEL = 8'h7f;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] TERM_AND = 8'h0f;
	localparam logic [7:0] TERM_OR = 8'h30;
	// reply prefixes, 3 characters each; model digits are arbitrary
	localparam logic [23:0] MODEL_PREFIX = 24'h303030;
	localparam logic [23:0] IO_PREFIX = 24'h492f4f;
	localparam logic [4:0] LEN_PREFIX = 5'h3;
	localparam logic [4:0] LEN_STATUS = 5'hb;
	localparam logic [4:0] LEN_IO = 5'h5;
	localparam logic [4:0] LEN_DATA = 5'h4;
	localparam logic [4:0] POS_SELFTEST = 5'h6;
	// output buffer
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {TERM_SINGLE, TERM_CRLF, TERM_LFCR, TERM_NONE} rtsi_term_t;
	typedef enum logic [1:0] {REPLY_DATA, REPLY_STATUS, REPLY_IO} rtsi_reply_t;
endpackage : rtsi_pkg

// ### hdl/rtsi_top.sv
// trigger mode, output terminator and one-shot status reply interpreter
//
// Summary of operation
// RULE1 - eight trigger codes; even start, odd stop
// RULE2 - reset or device clear selects trigger mode 6
// RULE3 - start trigger runs from next location
// RULE4 - step mode: each trigger advances pointer once
// RULE5 - stop trigger halts execution immediately
// RULE6 - terminator defaults to CR LF after clear
// RULE7 - terminator command sets any allowed character
// RULE8 - LF gives CR LF, CR gives LF CR, DEL none
// RULE9 - status 0 sends model prefix plus mode bytes
// RULE10 - status 1 sends input,output as decimal 0-15
// RULE11 - status reply replaces only next talk reply
// RULE12 - service request field: two decimal digits
// RULE13 - I/O prefix only in prefix modes 0,2,4
// RULE14 - model prefix only in prefix modes 0,2,4
// RULE15 - terminator field: last byte AND 0f OR 30
// RULE16 - self-test byte set by reset/command, cleared on read
// RULE17 - port number weights bit 3 down to 0
// RULE18 - controller reads status right after selecting it
// RULE19 - forbidden terminator rejected, old setting kept
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps

module rtsi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		in_ready = (cnt_q != DEPTH[AW:0]);
		out_valid = (cnt_q != '0);
		out_data = mem_q[rd_q];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage needs no reset; only valid words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule : rtsi_fifo

module rtsi_top (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_LETTER,
	input wire logic [7:0] CMD_ARG,
	input wire logic CMD_EXEC,
	input wire logic BUS_TALK,
	input wire logic BUS_GET,
	input wire logic BUS_CLEAR,
	input wire logic EXT_TRIG,
	input wire logic [3:0] IO_IN,
	input wire logic [3:0] IO_OUT,
	input wire logic DWELL_DONE,
	output logic PROG_RUN,
	output logic [7:0] PROG_PTR,
	output logic CMD_ILLEGAL,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY
);
	import rtsi_pkg::*;

	function automatic logic [7:0] digit(input logic [3:0] v);
		digit = CH_ZERO | {4'h0, v};
	endfunction : digit

	// tens and ones of a value below 100
	function automatic logic [15:0] two_digits(input logic [6:0] v);
		logic [6:0] tens;
		logic [6:0] ones;
		tens = v / 7'd10;
		ones = v - 7'(tens * 7'd10);
		two_digits = {digit(tens[3:0]), digit(ones[3:0])};
	endfunction : two_digits

	function automatic logic forbidden(input logic [7:0] c);
		forbidden = (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h30 && c <= 8'h39) || c == 8'h20 ||
			c == 8'h2b || c == 8'h2d || c == 8'h2f || c == 8'h2c || c == 8'h2e || c == 8'h65;
	endfunction : forbidden

	function automatic logic prefix_on(input logic [2:0] g);
		prefix_on = !g[0];
	endfunction : prefix_on

	// pin synchronisers
	logic [1:0] trig_sync_q;
	logic trig_prev_q;
	logic [3:0] io_meta_q, io_in_q;
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			trig_sync_q <= 2'h0;
			trig_prev_q <= 1'b0;
			io_meta_q <= 4'h0;
			io_in_q <= 4'h0;
		end else begin
			trig_sync_q <= {trig_sync_q[0], EXT_TRIG};
			trig_prev_q <= trig_sync_q[1];
			io_meta_q <= IO_IN;
			io_in_q <= io_meta_q;
		end
	end
	logic ext_edge;
	assign ext_edge = trig_sync_q[1] && !trig_prev_q;

	// control state
	logic [31:0] cfg_q, cfg_d, data_q, data_d;
	logic [2:0] trig_q, trig_d, prefix_q, prefix_d;
	rtsi_term_t term_q, term_d;
	logic [7:0] term_last_q, term_last_d, term_char_q, term_char_d;
	logic [6:0] srq_q, srq_d;
	rtsi_reply_t pend_q, pend_d;
	logic selftest_q, selftest_d, illegal_q, illegal_d, run_q, run_d;
	logic [7:0] ptr_q, ptr_d;
	logic apb_wr, apb_rd, stim, talk_start, selftest_read;
	logic [1:0] prog_mode;
	logic [31:0] stat_word;

	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PWRITE;
	assign prog_mode = cfg_q[CFG_P_LSB +: 2];

	always_comb begin
		unique case (trig_q[2:1]) // see RULE1
			2'h0: stim = BUS_TALK;
			2'h1: stim = BUS_GET;
			2'h2: stim = CMD_EXEC;
			default: stim = ext_edge;
		endcase
	end

	always_comb begin
		stat_word = 32'h0;
		stat_word[STAT_TRIG_LSB +: 3] = trig_q;
		stat_word[STAT_RUN_BIT] = run_q;
		stat_word[STAT_TERM_LSB +: 2] = term_q;
		stat_word[STAT_SELFTEST_BIT] = selftest_q;
		stat_word[STAT_ILLEGAL_BIT] = illegal_q;
		stat_word[STAT_PTR_LSB +: 8] = ptr_q;
		stat_word[STAT_SRQ_LSB +: 7] = srq_q;
		stat_word[STAT_PREFIX_LSB +: 3] = prefix_q;
	end

	always_comb begin
		cfg_d = cfg_q;
		data_d = data_q;
		trig_d = trig_q;
		prefix_d = prefix_q;
		term_d = term_q;
		term_last_d = term_last_q;
		term_char_d = term_char_q;
		srq_d = srq_q;
		pend_d = pend_q;
		selftest_d = selftest_q;
		illegal_d = illegal_q;
		run_d = run_q;
		ptr_d = ptr_q;
		if (apb_wr && PADDR == ADDR_CFG) begin
			cfg_d = PWDATA;
		end
		if (apb_wr && PADDR == ADDR_DATA) begin
			data_d = PWDATA;
		end
		if (apb_wr && PADDR == ADDR_STAT && PWDATA[STAT_ILLEGAL_BIT]) begin
			illegal_d = 1'b0;
		end
		if (talk_start) begin
			pend_d = REPLY_DATA; // see RULE11
		end
		if (selftest_read) begin
			selftest_d = 1'b0; // see RULE16
		end
		if (run_q && DWELL_DONE) begin
			ptr_d = ptr_q + 8'h1;
		end
		if (stim) begin
			if (prog_mode == PROG_STEP) begin
				ptr_d = ptr_q + 8'h1; // see RULE4
			end else if (!trig_q[0]) begin
				run_d = 1'b1;
				ptr_d = ptr_q + 8'h1; // see RULE3
			end else begin
				run_d = 1'b0; // see RULE5
			end
		end
		if (CMD_VALID) begin
			unique case (CMD_LETTER)
				CMD_T: begin
					if (CMD_ARG <= 8'h7) trig_d = CMD_ARG[2:0]; // see RULE1
					else illegal_d = 1'b1;
				end
				CMD_G: begin
					if (CMD_ARG <= {5'h0, PREFIX_MAX}) prefix_d = CMD_ARG[2:0];
					else illegal_d = 1'b1;
				end
				CMD_M: begin
					if (CMD_ARG <= SRQ_MAX) srq_d = CMD_ARG[6:0];
					else illegal_d = 1'b1;
				end
				CMD_U: begin
					if (CMD_ARG == 8'h0) pend_d = REPLY_STATUS; // see RULE9
					else if (CMD_ARG == 8'h1) pend_d = REPLY_IO; // see RULE10
					else illegal_d = 1'b1;
				end
				CMD_J: begin
					if (CMD_ARG == 8'h0) selftest_d = 1'b1; // see RULE16
					else illegal_d = 1'b1;
				end
				CMD_Y: begin
					if (CMD_ARG == CH_LF) begin
						term_d = TERM_CRLF; // see RULE8
						term_last_d = CH_LF;
					end else if (CMD_ARG == CH_CR) begin
						term_d = TERM_LFCR;
						term_last_d = CH_CR;
					end else if (CMD_ARG == CH_DEL) begin
						term_d = TERM_NONE;
						term_last_d = CH_DEL;
					end else if (forbidden(CMD_ARG)) begin
						illegal_d = 1'b1; // see RULE19
					end else begin
						term_d = TERM_SINGLE; // see RULE7
						term_char_d = CMD_ARG;
						term_last_d = CMD_ARG;
					end
				end
				default: ;
			endcase
		end
		if (BUS_CLEAR) begin
			trig_d = TRIG_DEFAULT; // see RULE2
			term_d = TERM_CRLF; // see RULE6
			term_last_d = CH_LF;
			prefix_d = PREFIX_DEFAULT;
			pend_d = REPLY_DATA;
			cfg_d[CFG_P_LSB +: 2] = PROG_STEP;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cfg_q <= CFG_RESET;
			data_q <= DATA_RESET;
			trig_q <= TRIG_DEFAULT; // see RULE2
			prefix_q <= PREFIX_DEFAULT;
			term_q <= TERM_CRLF; // see RULE6
			term_last_q <= CH_LF;
			term_char_q <= CH_LF;
			srq_q <= 7'h0;
			pend_q <= REPLY_DATA;
			selftest_q <= 1'b1; // see RULE16
			illegal_q <= 1'b0;
			run_q <= 1'b0;
			ptr_q <= 8'h0;
		end else begin
			cfg_q <= cfg_d;
			data_q <= data_d;
			trig_q <= trig_d;
			prefix_q <= prefix_d;
			term_q <= term_d;
			term_last_q <= term_last_d;
			term_char_q <= term_char_d;
			srq_q <= srq_d;
			pend_q <= pend_d;
			selftest_q <= selftest_d;
			illegal_q <= illegal_d;
			run_q <= run_d;
			ptr_q <= ptr_d;
		end
	end

	// apb slave, zero wait states
	always_comb begin
		PREADY = 1'b1;
		PSLVERR = PSEL && PENABLE && !(PADDR == ADDR_CFG || PADDR == ADDR_DATA || PADDR == ADDR_STAT);
		PRDATA = 32'h0;
		if (apb_rd) begin
			if (PADDR == ADDR_CFG) PRDATA = cfg_q;
			else if (PADDR == ADDR_DATA) PRDATA = data_q;
			else if (PADDR == ADDR_STAT) PRDATA = stat_word;
		end
	end

	// reply sequencer
	typedef enum logic [1:0] {RS_IDLE, RS_BODY, RS_TERM} rtsi_seq_t;
	rtsi_seq_t seq_q, seq_d;
	rtsi_reply_t kind_q, kind_d;
	logic [4:0] pos_q, pos_d, end_q, end_d, k;
	logic push, fifo_ready, term_last_pos;
	logic [7:0] body_byte, term_byte, push_byte, y_field;
	logic [15:0] srq_digits, in_digits, out_digits;

	assign srq_digits = two_digits(srq_q); // see RULE12
	assign in_digits = two_digits({3'h0, io_in_q}); // see RULE17
	assign out_digits = two_digits({3'h0, IO_OUT});
	assign y_field = (term_last_q & TERM_AND) | TERM_OR; // see RULE15
	assign k = pos_q - LEN_PREFIX;
	// a talk arriving mid-reply starts nothing; the running reply finishes
	assign talk_start = (seq_q == RS_IDLE) && BUS_TALK;
	assign selftest_read = push && (seq_q == RS_BODY) && (kind_q == REPLY_STATUS) && (pos_q == POS_SELFTEST);

	always_comb begin
		body_byte = 8'h0;
		if (pos_q < LEN_PREFIX) begin
			body_byte = (kind_q == REPLY_IO) ? IO_PREFIX[8'(23 - 8 * pos_q) -: 8] : MODEL_PREFIX[8'(23 - 8 * pos_q) -: 8];
		end else if (kind_q == REPLY_STATUS) begin
			unique case (k)
				5'h0: body_byte = digit(cfg_q[CFG_D_LSB +: 4]);
				5'h1: body_byte = digit(cfg_q[CFG_F_LSB +: 4]);
				5'h2: body_byte = digit({1'b0, prefix_q});
				5'h3: body_byte = digit({3'h0, selftest_q});
				5'h4: body_byte = digit(cfg_q[CFG_K_LSB +: 4]);
				5'h5: body_byte = digit({2'h0, prog_mode});
				5'h6: body_byte = digit(cfg_q[CFG_R_LSB +: 4]);
				5'h7: body_byte = digit({1'b0, trig_q});
				5'h8: body_byte = srq_digits[15:8];
				5'h9: body_byte = srq_digits[7:0];
				default: body_byte = y_field;
			endcase
		end else if (kind_q == REPLY_IO) begin
			unique case (k)
				5'h0: body_byte = in_digits[15:8];
				5'h1: body_byte = in_digits[7:0];
				5'h2: body_byte = CH_COMMA;
				5'h3: body_byte = out_digits[15:8];
				default: body_byte = out_digits[7:0];
			endcase
		end else begin
			body_byte = data_q[8'(31 - 8 * k) -: 8];
		end
	end

	always_comb begin
		unique case (term_q) // see RULE8
			TERM_CRLF: term_byte = (pos_q == 5'h0) ? CH_CR : CH_LF;
			TERM_LFCR: term_byte = (pos_q == 5'h0) ? CH_LF : CH_CR;
			default: term_byte = term_char_q;
		endcase
		term_last_pos = (term_q == TERM_SINGLE) || (pos_q != 5'h0);
	end

	always_comb begin
		seq_d = seq_q;
		kind_d = kind_q;
		pos_d = pos_q;
		end_d = end_q;
		push = 1'b0;
		push_byte = body_byte;
		unique case (seq_q)
			RS_IDLE: begin
				if (BUS_TALK) begin
					seq_d = RS_BODY;
					kind_d = pend_q; // see RULE11
					pos_d = (pend_q != REPLY_DATA && prefix_on(prefix_q)) ? 5'h0 : LEN_PREFIX; // see RULE13 see RULE14
					unique case (pend_q)
						REPLY_STATUS: end_d = LEN_PREFIX + LEN_STATUS;
						REPLY_IO: end_d = LEN_PREFIX + LEN_IO;
						default: end_d = LEN_PREFIX + LEN_DATA;
					endcase
				end
			end
			RS_BODY: begin
				push = fifo_ready;
				if (fifo_ready) begin
					pos_d = pos_q + 5'h1;
					if (pos_q == end_q - 5'h1) begin
						seq_d = (term_q == TERM_NONE) ? RS_IDLE : RS_TERM;
						pos_d = 5'h0;
					end
				end
			end
			default: begin
				push = fifo_ready;
				push_byte = term_byte;
				if (fifo_ready) begin
					pos_d = pos_q + 5'h1;
					if (term_last_pos) seq_d = RS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			seq_q <= RS_IDLE;
			kind_q <= REPLY_DATA;
			pos_q <= 5'h0;
			end_q <= 5'h0;
		end else begin
			seq_q <= seq_d;
			kind_q <= kind_d;
			pos_q <= pos_d;
			end_q <= end_d;
		end
	end

	rtsi_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RESET),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_byte),
		.out_valid(TX_VALID),
		.out_ready(TX_READY),
		.out_data(TX_DATA)
	);

	assign PROG_RUN = run_q;
	assign PROG_PTR = ptr_q;
	assign CMD_ILLEGAL = illegal_q;
endmodule : rtsi_top

// ### verification/rtsi_checker.sv
// port-level assertions of the interpreter
`timescale 1ns/1ps
module rtsi_checker
	import rtsi_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_LETTER,
	input wire logic [7:0] CMD_ARG,
	input wire logic BUS_CLEAR,
	input wire logic PROG_RUN,
	input wire logic [7:0] PROG_PTR,
	input wire logic CMD_ILLEGAL,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_READY
);
	logic acc, mapped, cmd_ok, y_bad, flag_clr;
	assign acc = PSEL && PENABLE;
	assign mapped = PADDR inside {ADDR_CFG, ADDR_DATA, ADDR_STAT};
	assign cmd_ok = CMD_VALID && !BUS_CLEAR;
	// plus through nine is one contiguous run
	assign y_bad = CMD_ARG inside {[8'h41:8'h5a], [8'h2b:8'h39], 8'h20, 8'h65};
	assign flag_clr = acc && PWRITE && PADDR == ADDR_STAT && PWDATA[7];
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	sequence s_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence s_bad_term;
		cmd_ok && CMD_LETTER == CMD_Y && y_bad;
	endsequence
	AST_READY: assert property (acc |-> PREADY)
		else $error("access without ready");
	AST_UNMAPPED: assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (acc && mapped |-> !PSLVERR)
		else $error("mapped access refused");
	AST_TX_HOLD: assert property (s_stall |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte lost in stall");
	AST_RESET_IDLE: assert property ($fell(RESET) |-> !PROG_RUN && PROG_PTR == 8'h00)
		else $error("program state not cleared");
	AST_BAD_TRIG: assert property (cmd_ok && CMD_LETTER == CMD_T && CMD_ARG > 8'h07 |=> CMD_ILLEGAL)
		else $error("trigger option above seven accepted");
	AST_BAD_TERM: assert property (s_bad_term |=> CMD_ILLEGAL)
		else $error("forbidden terminator accepted");
	AST_FLAG_KEPT: assert property (CMD_ILLEGAL && !flag_clr && !BUS_CLEAR |=> CMD_ILLEGAL)
		else $error("illegal flag lost");
	AST_PTR_STEP: assert property (PROG_PTR != $past(PROG_PTR) |-> PROG_PTR == $past(PROG_PTR) + 8'h01)
		else $error("pointer moved by more than one");
	AST_START_NEXT: assert property ($rose(PROG_RUN) |-> PROG_PTR == $past(PROG_PTR) + 8'h01)
		else $error("start did not move to next location");
endmodule : rtsi_checker

bind rtsi_top rtsi_checker chk_i (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.CMD_VALID(CMD_VALID), .CMD_LETTER(CMD_LETTER), .CMD_ARG(CMD_ARG), .BUS_CLEAR(BUS_CLEAR),
	.PROG_RUN(PROG_RUN), .PROG_PTR(PROG_PTR), .CMD_ILLEGAL(CMD_ILLEGAL), .TX_DATA(TX_DATA),
	.TX_VALID(TX_VALID), .TX_READY(TX_READY));

// ### verification/rtsi_ctrl_model.sv
// bus controller model taking reply bytes off the talker stream
`timescale 1ns/1ps
module rtsi_ctrl_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic [3:0] cnt_q;
	// slow stalls eight cycles at a time, enough to fill the buffer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			tx_ready <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			tx_ready <= !slow || cnt_q[3];
			if (tx_valid && tx_ready)
				got.push_back(tx_data);
		end
	end
endmodule : rtsi_ctrl_model

// ### verification/rtsi_top_tb.sv
// self-checking bench of the trigger, terminator and status interpreter
`timescale 1ns/1ps
module rtsi_top_tb;
	import rtsi_pkg::*;
	logic clk, rst, psel, penable, pwrite, cmd_valid, slow;
	logic pready, pslverr, prog_run, cmd_illegal, tx_valid, tx_ready;
	logic [7:0] paddr, cmd_letter, cmd_arg, prog_ptr, tx_data;
	logic [31:0] pwdata, prdata;
	logic [5:0] ev;
	logic [3:0] io_in, io_out;
	int failures, check_count;
	string bad = "A5 +-/,.eZ";
	// out-of-range options of the numeric commands
	logic [15:0] refuse [4] = '{{CMD_G, 8'h06}, {CMD_M, 8'h64}, {CMD_U, 8'h02}, {CMD_J, 8'h01}};
	rtsi_top dut (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMD_VALID(cmd_valid),
		.CMD_LETTER(cmd_letter), .CMD_ARG(cmd_arg), .CMD_EXEC(ev[2]), .BUS_TALK(ev[0]), .BUS_GET(ev[1]),
		.BUS_CLEAR(ev[3]), .EXT_TRIG(ev[4]), .IO_IN(io_in), .IO_OUT(io_out), .DWELL_DONE(ev[5]),
		.PROG_RUN(prog_run), .PROG_PTR(prog_ptr), .CMD_ILLEGAL(cmd_illegal), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready));
	rtsi_ctrl_model tk (.clk(clk), .rst(rst), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 50);
		// a wait that runs out counts as a mismatch
		chk("pready", 32'h1, pready);
		chk("pslverr", err, pslverr);
		if (!wr)
			chk("prdata", exp, prdata);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cmd(input logic [7:0] l, input logic [7:0] a);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_letter <= l;
		cmd_arg <= a;
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask : cmd
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= 6'h00;
	endtask : pulse
	task automatic flag(input logic exp);
		@(posedge clk);
		chk("illegal flag", exp, cmd_illegal);
	endtask : flag
	task automatic talk(input string s);
		int n;
		pulse(0);
		n = 0;
		while (tk.got.size() < s.len() && n < 300) begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		chk("reply length", s.len(), tk.got.size());
		foreach (tk.got[i])
			chk("reply byte", s[i], tk.got[i]);
		tk.got.delete();
	endtask : talk
	task automatic final_report();
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, cmd_valid, slow} = 5'h00;
		{paddr, cmd_letter, cmd_arg, pwdata} = 56'h0;
		ev = 6'h00;
		io_in = 4'ha;
		io_out = 4'h5;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, ADDR_STAT, 32'h0, 32'h56, 1'b0);
		apb(1'b0, ADDR_CFG, 32'h0, 32'h2, 1'b0);
		apb(1'b0, ADDR_DATA, 32'h0, DATA_RESET, 1'b0);
		apb(1'b1, ADDR_STAT, 32'h37, 32'h0, 1'b0);
		apb(1'b0, ADDR_STAT, 32'h0, 32'h56, 1'b0);
		apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h10, 32'h1234, 32'h0, 1'b1);
		cmd(CMD_U, 8'h00);
		slow <= 1'b1;
		talk("0000001020600:\015\012");
		slow <= 1'b0;
		talk("0000\015\012");
		apb(1'b0, ADDR_STAT, 32'h0, 32'h16, 1'b0);
		cmd(CMD_G, 8'h01);
		cmd(CMD_M, 8'h0c);
		cmd(CMD_Y, CH_CR);
		cmd(CMD_U, 8'h01);
		talk("10,05\012\015");
		cmd(CMD_U, 8'h00);
		talk("0010020612=\012\015");
		for (int i = 0; i < bad.len(); i++) begin
			cmd(CMD_Y, bad[i]);
			flag(1'b1);
			apb(1'b1, ADDR_STAT, 32'h80, 32'h0, 1'b0);
		end
		foreach (refuse[j]) begin
			cmd(refuse[j][15:8], refuse[j][7:0]);
			flag(1'b1);
			apb(1'b1, ADDR_STAT, 32'h80, 32'h0, 1'b0);
		end
		cmd(CMD_T, 8'h08);
		flag(1'b1);
		apb(1'b1, ADDR_STAT, 32'h80, 32'h0, 1'b0);
		flag(1'b0);
		apb(1'b0, ADDR_STAT, 32'h0, 32'h010c_0026, 1'b0);
		cmd(CMD_Y, 8'h23);
		talk("0000#");
		cmd(CMD_Y, CH_DEL);
		talk("0000");
		cmd(CMD_J, 8'h00);
		cmd(CMD_U, 8'h00);
		talk("0011020612?");
		pulse(3);
		apb(1'b0, ADDR_STAT, 32'h0, 32'h000c_0016, 1'b0);
		talk("0000\015\012");
		cmd(CMD_U, 8'h01);
		talk("I/O10,05\015\012");
		apb(1'b1, ADDR_CFG, PROG_CONT, 32'h0, 1'b0);
		for (int m = 0; m < 8; m++) begin
			cmd(CMD_T, m[7:0]);
			pulse(m / 2 == 3 ? 4 : m / 2);
			repeat (6) @(posedge clk);
			chk("run", !m[0], prog_run);
			chk("pointer", m / 2 + 1, prog_ptr);
		end
		repeat (20) @(posedge clk);
		tk.got.delete();
		apb(1'b1, ADDR_CFG, PROG_STEP, 32'h0, 1'b0);
		cmd(CMD_T, 8'h07);
		pulse(4);
		pulse(4);
		repeat (6) @(posedge clk);
		chk("step pointer", 32'h6, prog_ptr);
		chk("step run", 32'h0, prog_run);
		apb(1'b1, ADDR_CFG, PROG_SINGLE, 32'h0, 1'b0);
		cmd(CMD_T, 8'h06);
		pulse(4);
		repeat (6) @(posedge clk);
		chk("single run", 32'h1, prog_run);
		chk("single pointer", 32'h7, prog_ptr);
		pulse(5);
		repeat (2) @(posedge clk);
		chk("dwell pointer", 32'h8, prog_ptr);
		final_report();
	end
endmodule : rtsi_top_tb
